// File: common/fpc_link_if.sv
/*
 * synchronised view of the configuration pins, passed from the
 * synchroniser to the loader.
 * assumes both ends run on mclk.
 */
interface fpc_link_if;
   logic rise;
   logic fall;
   logic trig_low;
   logic [31:0] data;
   modport drive (output rise, output fall, output trig_low, output data);
   modport take (input rise, input fall, input trig_low, input data);
endinterface

// File: common/fpc_pkg.sv
/*
 * types shared by the configuration port modules.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package fpc_pkg;
   // loader states
   typedef enum logic [2:0] {
      st_por = 3'b000,
      st_clear = 3'b001,
      st_load = 3'b010,
      st_init = 3'b011,
      st_user = 3'b100
   } fpc_state_e;
   typedef logic [23:0] fpc_count_t;
endpackage

// File: common/fpc_regs.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * passive parallel configuration port.
 * assumes a word-wide register port with a 4-bit word address.
 */
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// register word addresses
`define FPC_A_CTRL 4'h0
`define FPC_A_STATUS 4'h1
`define FPC_A_COUNT 4'h2
`define FPC_A_EXPECT 4'h3
`define FPC_A_LAST 4'h4
`define FPC_A_IRQ_STAT 4'h5
`define FPC_A_IRQ_MASK 4'h6
`define FPC_A_UIO_OUT 4'h7
`define FPC_A_UIO_OE 4'h8
`define FPC_A_UIO_IN 4'h9

// control fields and reset values
`define FPC_CTRL_W16 0
`define FPC_CTRL_DECOMP 1
`define FPC_CTRL_SECURE 2
`define FPC_CTRL_RST 3'h0
`define FPC_EXPECT_RST 24'h00_0100

// interrupt status bits
`define FPC_IRQ_DONE 0
`define FPC_IRQ_USER 1
`define FPC_IRQ_ABORT 2
`define FPC_IRQ_TRIG 3

// clocks per word
`define FPC_RATIO_1 3'h1
`define FPC_RATIO_2 3'h2
`define FPC_RATIO_4 3'h4

// option word and bit that enable the init-complete output
`define FPC_OPT_WORD 24'h00_0000
`define FPC_OPT_BIT 0

// timing
`define FPC_INIT_FALLS 2'h2
`define FPC_MCLK_MHZ 10
`define FPC_POR_TIME_NS 100000
`define FPC_POR_CYCLES ((`FPC_POR_TIME_NS * `FPC_MCLK_MHZ + 999) / 1000)

`endif

// File: hw/fpc_link_sync.sv
/*
 * two-flop synchronisers for the configuration pins and edge finder for
 * the host-driven configuration clock.
 * assumes the host clock is several mclk periods long.
 */
module fpc_link_sync (
   // system
   input wire logic mclk,
   input wire logic rst,
   // pins
   input wire logic cfg_bit_clock,
   input wire logic reconfig_trigger_low,
   input wire logic [31:0] data_in,
   // synchronised side
   fpc_link_if.drive lk
);
   logic [33:0] s1_r, s2_r, s1_nxt, s2_nxt;
   logic clk_d_r, clk_d_nxt;

   // first flop feeds only the second; edges come from second and third
   always_comb begin
      s1_nxt = {cfg_bit_clock, reconfig_trigger_low, data_in};
      s2_nxt = s1_r;
      clk_d_nxt = s2_r[33];
   end

   // sync registers, trigger idles high
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_r <= {2'h1, 32'h0000_0000};
         s2_r <= {2'h1, 32'h0000_0000};
         clk_d_r <= 1'b0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         clk_d_r <= clk_d_nxt;
      end
   end

   // edge pulses and levels
   assign lk.rise = s2_r[33] & ~clk_d_r;
   assign lk.fall = ~s2_r[33] & clk_d_r;
   assign lk.trig_low = ~s2_r[32];
   assign lk.data = s2_r[31:0];
endmodule

// File: hw/fpc_loader.sv
/*
 * passive parallel configuration loader: takes 8- or 16-bit words on the
 * host clock, reports progress, enters user mode, hands pins to user i/o.
 * assumes host pins are asynchronous to mclk and open-drain pull-ups exist.
 */
// Notes on behaviour
// - in 8-bit mode one clock per word, two when decompression is on.
// - in 16-bit mode one clock, two with security only, four with decompression.
// - in user mode the trigger, status and load-complete lines all sit high.
// - driving the trigger low abandons user mode and starts a new load.
// - after power-up the status line is held low for the power-on delay.
// - the load-complete flag stays low from power-up until loading ends.
// - in user mode the configuration clock is ignored.
// - 16-bit words use data bits 15..0, 8-bit words bits 7..0 only.
// - after loading the 32 data pins become user i/o as set by software.
// - load-complete is released only after the whole bitstream arrived.
// - an enabled init-complete output goes low once its option bit loads.
`include "fpc_regs.svh"
module fpc_loader #(
   parameter int POR_CYC = `FPC_POR_CYCLES
) (
   // system
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic irq,
   // configuration pins
   input wire logic cfg_bit_clock,
   input wire logic reconfig_trigger_low,
   input wire logic [31:0] data_in,
   output logic [31:0] data_out,
   output logic [31:0] data_oe,
   output logic cfg_status_out,
   output logic cfg_status_oe,
   output logic load_complete_flag_out,
   output logic load_complete_flag_oe,
   output logic init_complete_out,
   output logic init_complete_oe
);
   fpc_link_if lk ();
   fpc_pkg::fpc_state_e state_r, state_nxt;
   fpc_pkg::fpc_count_t wcnt_r, wcnt_nxt, expect_r, expect_nxt;
   logic [15:0] por_r, por_nxt, last_r, last_nxt, word_in, word_now;
   logic [2:0] ecnt_r, ecnt_nxt, ctrl_r, ctrl_nxt, ratio;
   logic [1:0] fall_r, fall_nxt;
   logic [3:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
   logic [31:0] uo_r, uo_nxt, ue_r, ue_nxt, rdata_nxt;
   logic init_en_r, init_en_nxt, take;
   logic st_oe_nxt, dn_oe_nxt, in_oe_nxt, irq_nxt;
   logic [31:0] d_oe_nxt;

   fpc_link_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .cfg_bit_clock(cfg_bit_clock),
      .reconfig_trigger_low(reconfig_trigger_low),
      .data_in(data_in),
      .lk(lk)
   );

   // clocks per data word for width, decompression and security
   function automatic logic [2:0] ratio_f(input logic [2:0] c);
      if (!c[`FPC_CTRL_W16])
         ratio_f = c[`FPC_CTRL_DECOMP] ? `FPC_RATIO_2 : `FPC_RATIO_1;
      else if (c[`FPC_CTRL_DECOMP])
         ratio_f = `FPC_RATIO_4;
      else
         ratio_f = c[`FPC_CTRL_SECURE] ? `FPC_RATIO_2 : `FPC_RATIO_1;
   endfunction

   // word lanes by width
   assign word_in = ctrl_r[`FPC_CTRL_W16] ? lk.data[15:0] :
      {8'h00, lk.data[7:0]};
   assign ratio = ratio_f(ctrl_r);
   assign word_now = (ecnt_r == 3'h0) ? word_in : last_r;

   // loader sequence
   always_comb begin
      state_nxt = state_r;
      por_nxt = por_r;
      ecnt_nxt = ecnt_r;
      wcnt_nxt = wcnt_r;
      fall_nxt = fall_r;
      last_nxt = last_r;
      init_en_nxt = init_en_r;
      ev = 4'h0;
      take = 1'b0;
      case (state_r)
         fpc_pkg::st_por: begin
            if (por_r == 16'(POR_CYC - 1))
               state_nxt = fpc_pkg::st_clear;
            else
               por_nxt = por_r + 16'h0001;
         end
         fpc_pkg::st_clear: begin
            ecnt_nxt = 3'h0;
            wcnt_nxt = 24'h00_0000;
            fall_nxt = 2'h0;
            init_en_nxt = 1'b0;
            if (!lk.trig_low)
               state_nxt = fpc_pkg::st_load;
         end
         fpc_pkg::st_load: begin
            if (lk.rise) begin
               if (ecnt_r == 3'h0)
                  last_nxt = word_in;
               if (ecnt_r == 3'(ratio - 3'h1)) begin
                  take = 1'b1;
                  ecnt_nxt = 3'h0;
                  wcnt_nxt = wcnt_r + 24'h00_0001;
                  if (wcnt_r == `FPC_OPT_WORD && word_now[`FPC_OPT_BIT])
                     init_en_nxt = 1'b1;
                  if (wcnt_r == 24'(expect_r - 24'h00_0001)) begin
                     state_nxt = fpc_pkg::st_init;
                     ev[`FPC_IRQ_DONE] = 1'b1;
                  end
               end else begin
                  ecnt_nxt = ecnt_r + 3'h1;
               end
            end
         end
         fpc_pkg::st_init: begin
            if (lk.fall) begin
               if (fall_r == 2'(`FPC_INIT_FALLS - 2'h1)) begin
                  state_nxt = fpc_pkg::st_user;
                  ev[`FPC_IRQ_USER] = 1'b1;
               end else begin
                  fall_nxt = fall_r + 2'h1;
               end
            end
         end
         fpc_pkg::st_user: begin
            state_nxt = fpc_pkg::st_user;
         end
         default: state_nxt = fpc_pkg::st_clear;
      endcase
      // trigger low restarts from any state but power-on and clear
      if (lk.trig_low && state_r != fpc_pkg::st_por && state_r != fpc_pkg::st_clear) begin
         state_nxt = fpc_pkg::st_clear;
         ev[`FPC_IRQ_TRIG] = 1'b1;
         ev[`FPC_IRQ_ABORT] = (state_r == fpc_pkg::st_load);
      end
   end

   // pin drive levels follow the next state; status, load-complete and init-complete lines let go in user mode
   always_comb begin
      st_oe_nxt = (state_nxt == fpc_pkg::st_por) || (state_nxt == fpc_pkg::st_clear);
      dn_oe_nxt = (state_nxt != fpc_pkg::st_init) && (state_nxt != fpc_pkg::st_user);
      in_oe_nxt = init_en_nxt && (state_nxt != fpc_pkg::st_user);
      d_oe_nxt = (state_nxt == fpc_pkg::st_user) ? ue_nxt : 32'h0000_0000;
   end

   // register port: writes, sticky status with set over clear, read data
   always_comb begin
      ctrl_nxt = ctrl_r;
      expect_nxt = expect_r;
      mask_nxt = mask_r;
      uo_nxt = uo_r;
      ue_nxt = ue_r;
      stat_nxt = stat_r;
      rdata_nxt = 32'h0000_0000;
      if (wr) begin
         case (addr)
            `FPC_A_CTRL: ctrl_nxt = wdata[2:0];
            `FPC_A_EXPECT: expect_nxt = wdata[23:0];
            `FPC_A_IRQ_MASK: mask_nxt = wdata[3:0];
            `FPC_A_UIO_OUT: uo_nxt = wdata;
            `FPC_A_UIO_OE: ue_nxt = wdata;
            `FPC_A_IRQ_STAT: stat_nxt = stat_r & ~wdata[3:0];
            default: ;
         endcase
      end
      stat_nxt = stat_nxt | ev;
      if (rd) begin
         case (addr)
            `FPC_A_CTRL: rdata_nxt = {29'h0000_0000, ctrl_r};
            `FPC_A_STATUS: rdata_nxt = {27'h000_0000, init_en_r, 1'b0, state_r};
            `FPC_A_COUNT: rdata_nxt = {8'h00, wcnt_r};
            `FPC_A_EXPECT: rdata_nxt = {8'h00, expect_r};
            `FPC_A_LAST: rdata_nxt = {16'h0000, last_r};
            `FPC_A_IRQ_STAT: rdata_nxt = {28'h000_0000, stat_r};
            `FPC_A_IRQ_MASK: rdata_nxt = {28'h000_0000, mask_r};
            `FPC_A_UIO_OUT: rdata_nxt = uo_r;
            `FPC_A_UIO_OE: rdata_nxt = ue_r;
            `FPC_A_UIO_IN: rdata_nxt = lk.data;
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   // all state and outputs registered
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= fpc_pkg::st_por;
         por_r <= 16'h0000;
         ecnt_r <= 3'h0;
         wcnt_r <= 24'h00_0000;
         fall_r <= 2'h0;
         last_r <= 16'h0000;
         init_en_r <= 1'b0;
         ctrl_r <= `FPC_CTRL_RST;
         expect_r <= `FPC_EXPECT_RST;
         mask_r <= 4'h0;
         stat_r <= 4'h0;
         uo_r <= 32'h0000_0000;
         ue_r <= 32'h0000_0000;
         rdata <= 32'h0000_0000;
         irq <= 1'b0;
         data_out <= 32'h0000_0000;
         data_oe <= 32'h0000_0000;
         cfg_status_oe <= 1'b1;
         load_complete_flag_oe <= 1'b1;
         init_complete_oe <= 1'b0;
         cfg_status_out <= 1'b0;
         load_complete_flag_out <= 1'b0;
         init_complete_out <= 1'b0;
      end else begin
         state_r <= state_nxt;
         por_r <= por_nxt;
         ecnt_r <= ecnt_nxt;
         wcnt_r <= wcnt_nxt;
         fall_r <= fall_nxt;
         last_r <= last_nxt;
         init_en_r <= init_en_nxt;
         ctrl_r <= ctrl_nxt;
         expect_r <= expect_nxt;
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         uo_r <= uo_nxt;
         ue_r <= ue_nxt;
         rdata <= rdata_nxt;
         irq <= irq_nxt;
         data_out <= uo_nxt;
         data_oe <= d_oe_nxt;
         cfg_status_oe <= st_oe_nxt;
         load_complete_flag_oe <= dn_oe_nxt;
         init_complete_oe <= in_oe_nxt;
         cfg_status_out <= 1'b0;
         load_complete_flag_out <= 1'b0;
         init_complete_out <= 1'b0;
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence two_falls_s;
      lk.fall && fall_r == 2'h1;
   endsequence

   chk_ratio_x8: assert property (take && !ctrl_r[`FPC_CTRL_W16] |->
      ecnt_r == (ctrl_r[`FPC_CTRL_DECOMP] ? 3'h1 : 3'h0))
      else $error("8-bit word taken after wrong clock count");
   chk_ratio_x16: assert property (take && ctrl_r[`FPC_CTRL_W16] |->
      ecnt_r == (ctrl_r[`FPC_CTRL_DECOMP] ? 3'h3 :
      (ctrl_r[`FPC_CTRL_SECURE] ? 3'h1 : 3'h0)))
      else $error("16-bit word taken after wrong clock count");
   chk_user_levels: assert property (state_r == fpc_pkg::st_user |->
      !cfg_status_oe && !load_complete_flag_oe && !init_complete_oe)
      else $error("line held low in user mode");
   chk_trigger_abort: assert property (state_r == fpc_pkg::st_user &&
      lk.trig_low |=> state_r == fpc_pkg::st_clear && cfg_status_oe &&
      stat_r[`FPC_IRQ_TRIG])
      else $error("trigger did not restart loading");
   chk_por_hold: assert property (state_r == fpc_pkg::st_por |-> cfg_status_oe)
      else $error("status released during power-on delay");
   chk_done_low: assert property (state_r == fpc_pkg::st_load |-> load_complete_flag_oe)
      else $error("load-complete released while loading");
   chk_clock_ignored: assert property (state_r == fpc_pkg::st_user &&
      !lk.trig_low |=> $stable(wcnt_r) && $stable(last_r) && state_r == fpc_pkg::st_user)
      else $error("clock activity changed state after loading");
   chk_narrow_bus: assert property (state_r == fpc_pkg::st_load && lk.rise &&
      ecnt_r == 3'h0 && !ctrl_r[`FPC_CTRL_W16] |=> last_r[15:8] == 8'h00)
      else $error("upper byte used in 8-bit mode");
   chk_user_io: assert property (state_r != fpc_pkg::st_user |-> data_oe == 32'h0000_0000)
      else $error("data pins driven before user mode");
   chk_done_count: assert property ($rose(state_r == fpc_pkg::st_init) |->
      wcnt_r == expect_r && !load_complete_flag_oe)
      else $error("load-complete released with wrong word count");
   chk_two_falls: assert property (state_r == fpc_pkg::st_init && !lk.trig_low
      ##0 two_falls_s |=> state_r == fpc_pkg::st_user)
      else $error("user mode not entered on second falling edge");
   chk_init_low: assert property (take && wcnt_r == `FPC_OPT_WORD &&
      word_now[`FPC_OPT_BIT] && !lk.trig_low |=> init_complete_oe)
      else $error("init-complete not driven low after option bit");
   chk_sample_rise: assert property (take |-> lk.rise && state_r == fpc_pkg::st_load)
      else $error("word taken without a rising clock edge");
endmodule

// File: test/fpc_host.sv
/*
 * host model that loads the configuration port over its pins.
 * assumes the bench calls its tasks one at a time from a single process.
 */
module fpc_host (
   // link pins
   output logic cfg_bit_clock,
   output logic reconfig_trigger_low,
   output logic [31:0] data_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle: clock still, trigger released, data lines driven to 0f0f0f0f
   initial begin
      cfg_bit_clock = 1'b0;
      reconfig_trigger_low = 1'b1;
      data_in = 32'h0f0f_0f0f;
   end
   // one 800 ns clock period, low half first so it rests high between words
   task automatic tick();
      cfg_bit_clock <= 1'b0;
      #400;
      cfg_bit_clock <= 1'b1;
      #400;
   endtask
   // pulse the trigger low to ask for a fresh load
   task automatic restart();
      reconfig_trigger_low <= 1'b0;
      #1000;
      reconfig_trigger_low <= 1'b1;
   endtask
   // one word held stable over all of its clocks
   task automatic send_word(input logic [31:0] w, input int ratio);
      data_in <= w;
      repeat (ratio) tick();
   endtask
   // two falling edges after the flag rises; data lines inverted
   task automatic finish();
      data_in <= ~data_in;
      tick();
      cfg_bit_clock <= 1'b0;
      #400;
   endtask
endmodule

// File: test/testbench.sv
/*
 * self-checking bench for the configuration loader.
 * assumes the host model fpc_host and pull-ups on the open-drain lines.
 */
`include "fpc_regs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // one load setting: control bits, clocks per word, option word
   typedef struct {
      logic [2:0] ctrl;
      int ratio;
      logic [15:0] w0;
   } fpc_row_s;
   fpc_row_s rows [8] = '{
      '{3'h0, 1, 16'hc3a1}, '{3'h4, 1, 16'h5a72}, '{3'h2, 2, 16'h0e35},
      '{3'h6, 2, 16'h7c18}, '{3'h1, 1, 16'h9b4f}, '{3'h5, 2, 16'h2d66},
      '{3'h3, 4, 16'h41d7}, '{3'h7, 4, 16'hb8e0}};
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata, data_out, data_oe, data_in, d;
   logic irq, st_out, st_oe, lc_out, lc_oe, ic_out, ic_oe;
   logic cfg_bit_clock, reconfig_trigger_low;
   int bad_count = 0;
   int n_checks = 0;
   // device and host
   fpc_loader #(.POR_CYC(4)) dut_u (.mclk(mclk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .cfg_bit_clock(cfg_bit_clock), .reconfig_trigger_low(reconfig_trigger_low),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .cfg_status_out(st_out), .cfg_status_oe(st_oe),
      .load_complete_flag_out(lc_out), .load_complete_flag_oe(lc_oe),
      .init_complete_out(ic_out), .init_complete_oe(ic_oe));
   fpc_host host_u (.cfg_bit_clock(cfg_bit_clock),
      .reconfig_trigger_low(reconfig_trigger_low), .data_in(data_in));
   // 100 ns system clock
   always #50 mclk = ~mclk;
   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // counts, verdict, end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // register port cycles
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      v = rdata;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] v;
      reg_rd(a, v);
      check(v, e);
   endtask
   // bounded wait for the status line to be let go
   task automatic wait_load();
      int n;
      n = 0;
      while (st_oe !== 1'b0) begin
         @(negedge mclk);
         n++;
         if (n > 100) begin
            check(st_oe, 1'b0);
            print_verdict();
         end
      end
   endtask
   // one full load, entry to user mode, then clock activity in user mode
   task automatic run_row(input fpc_row_s r);
      logic [15:0] w;
      reg_wr(`FPC_A_CTRL, {29'h0, r.ctrl});
      host_u.restart();
      wait_load();
      check(lc_oe, 1'b1);
      check(data_oe, 32'h0);
      for (int k = 0; k < 3; k++) begin
         w = r.w0 + 16'(k * 'h1111);
         host_u.send_word({16'ha5c3, w}, (k < 2) ? r.ratio : r.ratio - 1);
      end
      repeat (6) @(posedge mclk);
      rd_chk(`FPC_A_COUNT, 32'h2);
      check(lc_oe, 1'b1);
      host_u.send_word({16'ha5c3, w}, 1);
      repeat (6) @(posedge mclk);
      check(lc_oe, 1'b0);
      rd_chk(`FPC_A_COUNT, 32'h3);
      rd_chk(`FPC_A_LAST, r.ctrl[0] ? {16'h0, w} : {24'h0, w[7:0]});
      rd_chk(`FPC_A_STATUS, {27'h0, r.w0[0], 4'h3});
      check(ic_oe, r.w0[0]);
      check(irq, 1'b1);
      reg_wr(`FPC_A_IRQ_STAT, 32'h1);
      rd_chk(`FPC_A_IRQ_MASK, 32'h1);
      check(irq, 1'b0);
      host_u.finish();
      repeat (6) @(posedge mclk);
      reg_rd(`FPC_A_STATUS, d);
      check(d[2:0], 3'h4);
      check({st_oe, lc_oe, ic_oe, reconfig_trigger_low}, 4'h1);
      check(data_oe, 32'h0000_ff00);
      check(data_out, 32'h1234_5678);
      check({29'h0, st_out, lc_out, ic_out}, 32'h0);
      host_u.send_word(32'hffff_ffff, 3);
      repeat (6) @(posedge mclk);
      rd_chk(`FPC_A_COUNT, 32'h3);
      rd_chk(`FPC_A_UIO_IN, 32'hffff_ffff);
      check(lc_oe, 1'b0);
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) begin
         @(negedge mclk);
         check({30'h0, st_oe, lc_oe}, 32'h3);
         check(data_oe, 32'h0);
      end
      rd_chk(`FPC_A_EXPECT, 32'h100);
      rd_chk(`FPC_A_CTRL, 32'h0);
      rd_chk(4'hf, 32'h0);
      reg_wr(`FPC_A_COUNT, 32'h5);
      rd_chk(`FPC_A_COUNT, 32'h0);
      reg_wr(`FPC_A_EXPECT, 32'h3);
      reg_wr(`FPC_A_UIO_OE, 32'h0000_ff00);
      reg_wr(`FPC_A_UIO_OUT, 32'h1234_5678);
      reg_wr(`FPC_A_IRQ_MASK, 32'h1);
      $display("power-on test done");
      foreach (rows[i]) begin
         run_row(rows[i]);
         $display("row %0d done", i);
      end
      // trigger dropped in mid-load: load abandoned, abort event raised
      host_u.restart();
      wait_load();
      reg_wr(`FPC_A_IRQ_STAT, 32'hf);
      reg_wr(`FPC_A_IRQ_MASK, 32'h4);
      host_u.send_word(32'h0000_0011, 1);
      host_u.restart();
      wait_load();
      reg_rd(`FPC_A_IRQ_STAT, d);
      check(d, 32'hc);
      check(irq, 1'b1);
      check(lc_oe, 1'b1);
      rd_chk(`FPC_A_COUNT, 32'h0);
      reg_wr(`FPC_A_IRQ_MASK, 32'h0);
      rd_chk(`FPC_A_IRQ_MASK, 32'h0);
      check(irq, 1'b0);
      reg_wr(`FPC_A_IRQ_STAT, 32'hf);
      rd_chk(`FPC_A_IRQ_STAT, 32'h0);
      $display("abort test done");
      // reset in mid-run: lines and registers back to their reset levels
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      check({30'h0, st_oe, lc_oe}, 32'h3);
      check(irq, 1'b0);
      check(data_oe, 32'h0);
      rd_chk(`FPC_A_STATUS, 32'h0);
      rd_chk(`FPC_A_EXPECT, 32'h100);
      $display("reset test done");
      print_verdict();
   end
endmodule
